// >>> pcio_pkg.sv
/*
 package for the protection-clear i/o pin: register map, field positions, reset values, timing.
 assumes a 100 mhz system clock and an axi4-lite master with 32-bit data.
*/
package pcio_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned PULSE_MIN_US = 30;
    localparam int unsigned PULSE_CYC = (PULSE_MIN_US * (CLK_HZ / 1_000_000));
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_LOWTIME = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam int unsigned CTRL_FUNC_LSB = 0;
    localparam int unsigned CTRL_INV_BIT = 2;
    localparam int unsigned CTRL_OVAL_LSB = 4;
    localparam logic [1:0] FUNC_PCLR = 2'h0;
    localparam logic [1:0] FUNC_IN = 2'h1;
    localparam logic [1:0] FUNC_OUT = 2'h2;
    localparam logic [1:0] OVAL_FALSE = 2'h0;
    localparam logic [1:0] OVAL_TRUE = 2'h1;
    localparam logic [1:0] OVAL_PWM = 2'h2;
    localparam logic [31:0] PERIOD_RST = 32'h000f4240;
    localparam logic [31:0] LOWTIME_RST = 32'h000186a0;
    localparam int unsigned ST_LEVEL_BIT = 0;
    localparam int unsigned ST_PROT_BIT = 1;
    localparam int unsigned ST_PULSE_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic in;
        logic out;
        logic oe;
    } pcio_pin_s;
    typedef enum logic [2:0] {
        PCIO_IDLE = 3'b001,
        PCIO_LOW = 3'b010,
        PCIO_WAIT_HI = 3'b100
    } pcio_rx_e;
endpackage

// >>> pcio_top.sv
/*
 protection-clear i/o pin logic with axi4-lite registers.
 assumes pin input asynchronous to aclk after the pad; pad logic resolves out/oe into the wire.
*/
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pcio_top #(
    parameter int unsigned PULSE_CYCLES = pcio_pkg::PULSE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pcio_pkg::pcio_pin_s pin_i,
    output pcio_pkg::pcio_pin_s pin_o,
    input wire logic prot_active,
    input wire logic load_on,
    output logic prot_clear
);
    import pcio_pkg::*;

    logic [1:0] func_ff;
    logic inv_ff;
    logic [1:0] oval_ff;
    logic [31:0] period_ff;
    logic [31:0] lowtime_ff;
    logic aw_ok_ff;
    logic w_ok_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic sync1_ff;
    logic sync2_ff;
    logic level_ff;
    pcio_rx_e rx_ff;
    logic [31:0] rx_cnt_ff;
    logic clear_ff;
    logic load_on_ff;
    logic tx_busy_ff;
    logic [31:0] tx_cnt_ff;
    logic pulse_seen_ff;
    logic [31:0] pwm_cnt_ff;
    logic do_write;
    logic [31:0] wmask;
    logic [31:0] ctrl_word;
    logic pin_true;
    logic pin_asserted;
    logic in_low;
    logic nxt_out;

    assign ctrl_word = {26'h0, oval_ff, 1'b0, inv_ff, func_ff};
    assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    assign do_write = aw_ok_ff && w_ok_ff && !bvalid_ff;

    // address and data may arrive in either order; each is held until both are in
    assign s_axi_awready = !aw_ok_ff && !bvalid_ff;
    assign s_axi_wready = !w_ok_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ok_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ok_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_ok_ff <= 1'b0;
                w_ok_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= (awaddr_ff == ADDR_CTRL || awaddr_ff == ADDR_PERIOD || awaddr_ff == ADDR_LOWTIME)
                    ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_ff && s_axi_bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // settings registers; a write to status is refused with slverr
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            func_ff <= FUNC_PCLR;
            inv_ff <= 1'b0;
            oval_ff <= OVAL_FALSE;
            period_ff <= PERIOD_RST;
            lowtime_ff <= LOWTIME_RST;
        end
        else if (do_write)
        begin
            case (awaddr_ff)
                ADDR_CTRL:
                begin
                    if (wstrb_ff[0])
                    begin
                        func_ff <= wdata_ff[CTRL_FUNC_LSB +: 2];
                        inv_ff <= wdata_ff[CTRL_INV_BIT];
                        oval_ff <= wdata_ff[CTRL_OVAL_LSB +: 2];
                    end
                end
                ADDR_PERIOD: period_ff <= (period_ff & ~wmask) | (wdata_ff & wmask);
                ADDR_LOWTIME: lowtime_ff <= (lowtime_ff & ~wmask) | (wdata_ff & wmask);
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_ff <= 1'b1;
            rresp_ff <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL: rdata_ff <= ctrl_word;
                ADDR_PERIOD: rdata_ff <= period_ff;
                ADDR_LOWTIME: rdata_ff <= lowtime_ff;
                ADDR_STATUS: rdata_ff <= {29'h0, pulse_seen_ff, prot_active, level_ff};
                default:
                begin
                    rdata_ff <= 32'h0;
                    rresp_ff <= RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_ff && s_axi_rready)
        begin
            rvalid_ff <= 1'b0;
        end
    end

    // two-stage synchroniser; only the second stage is looked at
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
        end
        else
        begin
            sync1_ff <= pin_i.in;
            sync2_ff <= sync1_ff;
        end
    end

    // a pulse is a low after high, low meaning the asserted sense after inversion
    // an electrically low pin is asserted unless inverted; idle pull-up must read as not asserted
    assign in_low = ~sync2_ff ^ inv_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            level_ff <= 1'b0;
        else
            level_ff <= in_low;
    end

    // the receiver ignores our own outgoing pulse so it cannot clear itself
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rx_ff <= PCIO_IDLE;
            rx_cnt_ff <= 32'h0;
            clear_ff <= 1'b0;
        end
        else
        begin
            clear_ff <= 1'b0;
            case (rx_ff)
                PCIO_IDLE:
                begin
                    rx_cnt_ff <= 32'h0;
                    if (func_ff == FUNC_PCLR && !tx_busy_ff && in_low)
                        rx_ff <= PCIO_LOW;
                end
                PCIO_LOW:
                begin
                    if (!in_low || func_ff != FUNC_PCLR)
                        rx_ff <= PCIO_IDLE;
                    else if (rx_cnt_ff >= PULSE_CYCLES - 2)
                    begin
                        rx_ff <= PCIO_WAIT_HI;
                        clear_ff <= prot_active;
                    end
                    else
                        rx_cnt_ff <= rx_cnt_ff + 32'h1;
                end
                PCIO_WAIT_HI:
                begin
                    if (!in_low)
                        rx_ff <= PCIO_IDLE;
                end
                default: rx_ff <= PCIO_IDLE;
            endcase
        end
    end

    assign prot_clear = clear_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            load_on_ff <= 1'b0;
            tx_busy_ff <= 1'b0;
            tx_cnt_ff <= 32'h0;
            pulse_seen_ff <= 1'b0;
        end
        else
        begin
            load_on_ff <= load_on;
            if (tx_busy_ff)
            begin
                if (tx_cnt_ff >= PULSE_CYCLES - 1)
                    tx_busy_ff <= 1'b0;
                else
                    tx_cnt_ff <= tx_cnt_ff + 32'h1;
            end
            else if (func_ff == FUNC_PCLR && load_on && !load_on_ff && !prot_active)
            begin
                tx_busy_ff <= 1'b1;
                tx_cnt_ff <= 32'h0;
                pulse_seen_ff <= 1'b1;
            end
        end
    end

    // period and low time in clock cycles; a low time above the period keeps the pin low
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pwm_cnt_ff <= 32'h0;
        else if (func_ff != FUNC_OUT || oval_ff != OVAL_PWM || pwm_cnt_ff + 32'h1 >= period_ff)
            pwm_cnt_ff <= 32'h0;
        else
            pwm_cnt_ff <= pwm_cnt_ff + 32'h1;
    end

    always_comb
    begin
        case (oval_ff)
            OVAL_TRUE: pin_true = 1'b1;
            OVAL_PWM: pin_true = (pwm_cnt_ff < lowtime_ff);
            default: pin_true = 1'b0;
        endcase
        // asserted means electrically low before inversion
        pin_asserted = (func_ff == FUNC_OUT) ? pin_true : tx_busy_ff;
        nxt_out = pin_asserted ^ ~inv_ff;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_o <= '{in: 1'b0, out: 1'b1, oe: 1'b0};
        end
        else
        begin
            pin_o.in <= 1'b0;
            pin_o.out <= nxt_out;
            pin_o.oe <= (func_ff == FUNC_OUT) || (func_ff == FUNC_PCLR && tx_busy_ff);
        end
    end
endmodule // pcio_top
`default_nettype wire

// >>> pcio_chk.sv
/*
 checker for pcio_top: bus answers, clear pulses, driven pulse width.
 assumes it is bound inside pcio_top.
*/
`timescale 1ns/1ps
`default_nettype none
module pcio_chk #(
    parameter int unsigned PULSE_CYCLES = 3000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire pcio_pkg::pcio_pin_s pin_i,
    input wire pcio_pkg::pcio_pin_s pin_o,
    input wire logic prot_active,
    input wire logic prot_clear
);
    import pcio_pkg::*;
    int unsigned lo_ff;
    int unsigned oe_ff;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // run lengths restart on reset, so a run from before reset never counts
    always_ff @(posedge aclk)
    begin
        lo_ff <= (!aresetn || pin_i.in) ? 0 : lo_ff + 1;
    end
    always_ff @(posedge aclk)
    begin
        oe_ff <= (!aresetn || !pin_o.oe) ? 0 : oe_ff + 1;
    end
    a_clear_in_prot: assert property (prot_clear |-> prot_active || $past(prot_active))
        else $error("clear without protection");
    a_clear_single: assert property (prot_clear |=> !prot_clear)
        else $error("clear longer than one cycle");
    a_clear_width: assert property (prot_clear |-> lo_ff >= PULSE_CYCLES)
        else $error("clear after short pulse");
    a_drive_width: assert property ($fell(pin_o.oe) |-> oe_ff >= PULSE_CYCLES)
        else $error("driven pulse too short");
    a_own_pulse_mute: assert property (pin_o.oe |-> !prot_clear)
        else $error("clear while driving");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during rvalid");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready during bvalid");
    c_clear: cover property (prot_clear);
    c_pulse: cover property ($fell(pin_o.oe));
    c_read: cover property (s_axi_rvalid);
endmodule // pcio_chk
bind pcio_top pcio_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pin_i, .pin_o, .prot_active, .prot_clear);
`default_nettype wire

// >>> pcio_inst.sv
/*
 external instrument on the pin: pulls it low on command, times low pulses it sees.
 assumes a pulled-up wire resolved by the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module pcio_inst (
    input wire logic aclk,
    input wire logic pin_lvl,
    output logic drv_low
);
    int n_seen = 0;
    int w_low = 0;
    int w_last = 0;
    initial drv_low = 1'b0;
    // own pulses are not timed, only what the device drives
    always @(posedge aclk)
    begin
        if (!pin_lvl && !drv_low)
            w_low <= w_low + 1;
        else if (w_low != 0)
        begin
            n_seen <= n_seen + 1;
            w_last <= w_low;
            w_low <= 0;
        end
    end
    task automatic level(input logic lo);
        @(posedge aclk);
        drv_low <= lo;
    endtask
    task automatic send(input int w);
        level(1'b1);
        repeat (w - 1) @(posedge aclk);
        drv_low <= 1'b0;
    endtask
endmodule // pcio_inst
`default_nettype wire

// >>> pcio_top_tb.sv
/*
 self-checking bench for pcio_top: registers, output, input, pwm, clear and pulse.
 assumes the external instrument model and a pulled-up pin.
*/
`timescale 1ns/1ps
`default_nettype none
module pcio_top_tb;
    import pcio_pkg::*;
    localparam int unsigned PW = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, s_axi_rdata;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic prot_active = 1'b0, load_on = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, prot_clear, drv_low, lvl;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    pcio_pin_s pin_i, pin_o;
    logic [33:0] wq[$], rq[$];
    int err_total = 0, n_checks = 0, nclr = 0, cyc = 0;
    // released pin floats high through the pull-up
    assign lvl = pin_o.oe ? pin_o.out : !drv_low;
    assign pin_i = '{in: lvl, out: 1'b0, oe: 1'b0};
    pcio_top #(.PULSE_CYCLES(PW)) dut (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready, .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(rready), .pin_i, .pin_o,
        .prot_active, .load_on, .prot_clear);
    pcio_inst p (.aclk, .pin_lvl(lvl), .drv_low);
    initial
    begin
        forever #5 aclk = ~aclk;
    end
    task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        wq.push_back({r, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                awvalid <= 1'b0;
            if (s_axi_wready)
                wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        rq.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rready <= 1'b0;
    endtask
    function automatic logic [31:0] ctrl(input logic [1:0] f, input logic inv, input logic [1:0] ov);
        return (32'(ov) << CTRL_OVAL_LSB) | (32'(inv) << CTRL_INV_BIT) | (32'(f) << CTRL_FUNC_LSB);
    endfunction
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (s_axi_bvalid && bready)
            chk("bresp", wq.pop_front(), {s_axi_bresp, 32'h0});
        if (s_axi_rvalid && rready)
            chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (prot_clear === 1'b1)
            nclr <= nclr + 1;
        if (cyc == 20000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    initial
    begin
        logic lv, pa;
        int lt, n0;
        void'($urandom(89635));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_CTRL, 32'h0, RESP_OKAY);
        rd(ADDR_PERIOD, PERIOD_RST, RESP_OKAY);
        rd(ADDR_LOWTIME, LOWTIME_RST, RESP_OKAY);
        rd(8'h10, 32'h0, RESP_SLVERR);
        wr(ADDR_STATUS, 32'h7, RESP_SLVERR);
        // byte lanes: only strobed bytes land, and control lives in the lowest lane
        wstrb <= 4'h1;
        wr(ADDR_PERIOD, 32'h12345678, RESP_OKAY);
        wstrb <= 4'he;
        wr(ADDR_CTRL, ctrl(FUNC_OUT, 1'b1, OVAL_TRUE), RESP_OKAY);
        wstrb <= 4'hf;
        rd(ADDR_PERIOD, {PERIOD_RST[31:8], 8'h78}, RESP_OKAY);
        rd(ADDR_CTRL, 32'h0, RESP_OKAY);
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_CTRL, ctrl(FUNC_OUT, i[0], i[1] ? OVAL_TRUE : OVAL_FALSE), RESP_OKAY);
            repeat (3) @(posedge aclk);
            chk("pin_o", {33'h1, ~(i[1] ^ i[0])}, {32'h0, pin_o.oe, pin_o.out});
        end
        for (int k = 0; k < 4; k++)
        begin
            lv = 1'($urandom);
            pa = 1'($urandom);
            p.level(lv);
            prot_active <= pa;
            wr(ADDR_CTRL, ctrl(FUNC_IN, k[0], OVAL_FALSE), RESP_OKAY);
            repeat (6) @(posedge aclk);
            chk("pin_oe", 34'h0, {33'h0, pin_o.oe});
            rd(ADDR_STATUS, {30'h0, pa, lv ^ k[0]}, RESP_OKAY);
        end
        p.level(1'b0);
        lt = 1 + $urandom % 8;
        wr(ADDR_PERIOD, 32'ha, RESP_OKAY);
        wr(ADDR_LOWTIME, 32'(lt), RESP_OKAY);
        wr(ADDR_CTRL, ctrl(FUNC_OUT, 1'b0, OVAL_PWM), RESP_OKAY);
        repeat (5) @(posedge aclk);
        n0 = 0;
        repeat (20)
        begin
            @(posedge aclk);
            n0 += int'(!pin_o.out);
        end
        chk("pwm_low", 34'(2 * lt), 34'(n0));
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        for (int j = 0; j < 3; j++)
        begin
            n0 = nclr;
            prot_active <= (j != 2);
            p.send(j == 1 ? PW - 3 : PW + 5);
            repeat (PW + 10) @(posedge aclk);
            chk("prot_clear", 34'(j == 0), 34'(nclr - n0));
        end
        prot_active <= 1'b0;
        for (int m = 0; m < 2; m++)
        begin
            n0 = p.n_seen;
            load_on <= 1'b1;
            repeat (PW + 10) @(posedge aclk);
            chk("pulse_out", 34'(m == 0), 34'(p.n_seen - n0));
            load_on <= 1'b0;
            prot_active <= 1'b1;
            @(posedge aclk);
        end
        chk("pulse_w", 34'h1, 34'(p.w_last >= PW));
        rd(ADDR_STATUS, 32'h6, RESP_OKAY);
        tally_and_finish();
    end
endmodule // pcio_top_tb
`default_nettype wire
